// File: bfl_pkg.sv
// Behaviour
// - Failure output sets latch; only clear input or reset_i resets
// - Single-phase start: pole trip and same-phase detector
// - Single-phase start runs failure and reissue timers
// - Single-phase reissue drives faulted pole only
// - Single-phase failure expiry asserts failure and latch
// - Separate single-phase timers per phase
// - Detector drop stops dependent timers immediately
// - Six phase detectors, one ground, independent settings
// - Three-phase start: trip with any three-phase detector
// - Three-phase trip is OR of three sources
// - Three-phase start runs timers; reissue drives three-pole
// - Three-phase failure expiry asserts failure and latch
// - Contact start only while some pole closed
// - Ground start with ground detector starts no-overcurrent path
// - No-overcurrent start runs timers; reissue drives three-pole
// - No-overcurrent failure expiry asserts failure and latch
// - Delays 0.05 to 2 s, 0.01 s steps, default 0.5 s
package bfl_pkg;
	localparam int unsigned CLK_HZ = 125000000;
	localparam int unsigned TICK_MS = 10;
	localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
	localparam int unsigned DELAY_W = 8;
	localparam logic [DELAY_W-1:0] DELAY_MIN = 8'h05;
	localparam logic [DELAY_W-1:0] DELAY_MAX = 8'hC8;
	localparam logic [DELAY_W-1:0] DELAY_DEFAULT = 8'h32;
	localparam int unsigned PICKUP_W = 12;
	localparam int unsigned PHASES = 3;
endpackage : bfl_pkg

// File: bfl_breaker_failure.sv
`timescale 1ns/1ns
`default_nettype none
module bfl_breaker_failure #(
	parameter int unsigned TICK_CYCLES = bfl_pkg::TICK_CYCLES,
	parameter int unsigned PICKUP_W = bfl_pkg::PICKUP_W
) (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic reset_i,
	// Current magnitudes per phase and ground
	input wire logic [PICKUP_W-1:0] phase_a_mag_i,
	input wire logic [PICKUP_W-1:0] phase_b_mag_i,
	input wire logic [PICKUP_W-1:0] phase_c_mag_i,
	input wire logic [PICKUP_W-1:0] ground_mag_i,
	// Pickup settings
	input wire logic [PICKUP_W-1:0] single_pickup_i,
	input wire logic [PICKUP_W-1:0] three_pickup_i,
	input wire logic [PICKUP_W-1:0] ground_pickup_i,
	// Delay settings in 10 ms steps
	input wire logic [bfl_pkg::DELAY_W-1:0] single_fail_delay_i,
	input wire logic [bfl_pkg::DELAY_W-1:0] single_reissue_delay_i,
	input wire logic [bfl_pkg::DELAY_W-1:0] three_oc_fail_delay_i,
	input wire logic [bfl_pkg::DELAY_W-1:0] three_oc_reissue_delay_i,
	input wire logic [bfl_pkg::DELAY_W-1:0] no_oc_fail_delay_i,
	input wire logic [bfl_pkg::DELAY_W-1:0] no_oc_reissue_delay_i,
	// Trip and position inputs
	input wire logic unit_enable_i,
	input wire logic ext_pole_a_trip_i,
	input wire logic ext_pole_b_trip_i,
	input wire logic ext_pole_c_trip_i,
	input wire logic ext_three_pole_trip_i,
	input wire logic internal_three_pole_trip_i,
	input wire logic contact_position_start_i,
	input wire logic pole_a_open_in_i,
	input wire logic pole_b_open_in_i,
	input wire logic pole_c_open_in_i,
	input wire logic all_poles_open_in_i,
	input wire logic ground_path_start_i,
	input wire logic latch_clear_in_i,
	// Outputs
	output logic [2:0] pole_reissue_o,
	output logic three_pole_reissue_o,
	output logic breaker_fail_out_o,
	output logic breaker_fail_latched_o,
	output logic [2:0] single_pickup_o,
	output logic [2:0] three_pickup_o,
	output logic ground_pickup_o
);
	initial begin
		if (TICK_CYCLES < 2 || PICKUP_W < 1) begin
			$error("bfl_breaker_failure: bad parameter");
		end
	end

	localparam int unsigned TCW = $clog2(TICK_CYCLES);
	localparam int unsigned DW = bfl_pkg::DELAY_W;
	localparam int unsigned PHASES_C = bfl_pkg::PHASES;
	// Path index map: one per phase, then with and without overcurrent
	localparam int unsigned OC_PATH = PHASES_C;
	localparam int unsigned NO_OC_PATH = PHASES_C + 1;
	localparam int unsigned PATHS = PHASES_C + 2;

	// Clamp setting into 0.05 to 2 s; default on zero
	function automatic logic [DW-1:0] clamp_delay(input logic [DW-1:0] d);
		if (d == '0) begin
			clamp_delay = bfl_pkg::DELAY_DEFAULT;
		end else if (d < bfl_pkg::DELAY_MIN) begin
			clamp_delay = bfl_pkg::DELAY_MIN;
		end else if (d > bfl_pkg::DELAY_MAX) begin
			clamp_delay = bfl_pkg::DELAY_MAX;
		end else begin
			clamp_delay = d;
		end
	endfunction : clamp_delay

	// Tick divider
	logic [TCW-1:0] tick_cnt_reg;
	logic tick_reg;
	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			tick_cnt_reg <= '0;
			tick_reg <= 1'b0;
		end else if (tick_cnt_reg == TCW'(TICK_CYCLES - 1)) begin
			tick_cnt_reg <= '0;
			tick_reg <= 1'b1;
		end else begin
			tick_cnt_reg <= tick_cnt_reg + 1'b1;
			tick_reg <= 1'b0;
		end
	end

	// Detectors registered every cycle: dropout within one clock, far under 5 ms
	logic [PICKUP_W-1:0] mag [PHASES_C];
	always_comb begin
		mag[0] = phase_a_mag_i;
		mag[1] = phase_b_mag_i;
		mag[2] = phase_c_mag_i;
	end
	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			single_pickup_o <= '0;
			three_pickup_o <= '0;
			ground_pickup_o <= 1'b0;
		end else begin
			for (int i = 0; i < PHASES_C; i++) begin
				single_pickup_o[i] <= mag[i] >= single_pickup_i;
				three_pickup_o[i] <= mag[i] >= three_pickup_i;
			end
			ground_pickup_o <= ground_mag_i >= ground_pickup_i;
		end
	end

	// Start conditions
	logic [2:0] pole_trip;
	logic three_trip;
	logic some_closed;
	logic [PATHS-1:0] start;
	always_comb begin
		pole_trip = {ext_pole_c_trip_i, ext_pole_b_trip_i, ext_pole_a_trip_i};
		three_trip = internal_three_pole_trip_i | (&pole_trip) | ext_three_pole_trip_i;
		some_closed = !(pole_a_open_in_i & pole_b_open_in_i & pole_c_open_in_i) | !all_poles_open_in_i;
		start[2:0] = {3{unit_enable_i}} & pole_trip & single_pickup_o;
		start[OC_PATH] = unit_enable_i & three_trip & (|three_pickup_o);
		start[NO_OC_PATH] = unit_enable_i & ((contact_position_start_i & some_closed)
			| (ground_path_start_i & ground_pickup_o));
	end

	// Timer pairs: 0..2 per phase, 3 three-phase with overcurrent, 4 without
	logic [DW-1:0] fail_cnt_reg [PATHS];
	logic [DW-1:0] reissue_cnt_reg [PATHS];
	logic [DW-1:0] fail_lim [PATHS];
	logic [DW-1:0] reissue_lim [PATHS];
	logic [PATHS-1:0] fail_done;
	logic [PATHS-1:0] reissue_done;
	always_comb begin
		for (int i = 0; i < PHASES_C; i++) begin
			fail_lim[i] = clamp_delay(single_fail_delay_i);
			reissue_lim[i] = clamp_delay(single_reissue_delay_i);
		end
		fail_lim[OC_PATH] = clamp_delay(three_oc_fail_delay_i);
		reissue_lim[OC_PATH] = clamp_delay(three_oc_reissue_delay_i);
		fail_lim[NO_OC_PATH] = clamp_delay(no_oc_fail_delay_i);
		reissue_lim[NO_OC_PATH] = clamp_delay(no_oc_reissue_delay_i);
		for (int i = 0; i < PATHS; i++) begin
			fail_done[i] = start[i] && fail_cnt_reg[i] >= fail_lim[i];
			reissue_done[i] = start[i] && reissue_cnt_reg[i] >= reissue_lim[i];
		end
	end

	// Both timers of a path start together and clear as the start drops
	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			for (int i = 0; i < PATHS; i++) begin
				fail_cnt_reg[i] <= '0;
				reissue_cnt_reg[i] <= '0;
			end
		end else begin
			for (int i = 0; i < PATHS; i++) begin
				if (!start[i]) begin
					fail_cnt_reg[i] <= '0;
					reissue_cnt_reg[i] <= '0;
				end else if (tick_reg) begin
					if (!fail_done[i]) begin
						fail_cnt_reg[i] <= fail_cnt_reg[i] + 1'b1;
					end
					if (!reissue_done[i]) begin
						reissue_cnt_reg[i] <= reissue_cnt_reg[i] + 1'b1;
					end
				end
			end
		end
	end

	// Outputs; latch set wins over clear so no failure is lost
	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			pole_reissue_o <= '0;
			three_pole_reissue_o <= 1'b0;
			breaker_fail_out_o <= 1'b0;
			breaker_fail_latched_o <= 1'b0;
		end else begin
			pole_reissue_o <= reissue_done[PHASES_C-1:0];
			three_pole_reissue_o <= reissue_done[OC_PATH] | reissue_done[NO_OC_PATH];
			breaker_fail_out_o <= |fail_done;
			if (|fail_done) begin
				breaker_fail_latched_o <= 1'b1;
			end else if (latch_clear_in_i) begin
				breaker_fail_latched_o <= 1'b0;
			end
		end
	end
endmodule : bfl_breaker_failure
`default_nettype wire

// File: bfl_breaker_failure_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module bfl_breaker_failure_asserts (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic reset_i,
	// Watched inputs
	input wire logic unit_enable_i,
	input wire logic ext_pole_a_trip_i,
	input wire logic latch_clear_in_i,
	// Watched outputs
	input wire logic [2:0] single_pickup_o,
	input wire logic [2:0] pole_reissue_o,
	input wire logic breaker_fail_out_o,
	input wire logic breaker_fail_latched_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (reset_i);
	AST_SET: assert property (breaker_fail_out_o |-> breaker_fail_latched_o) else $error("set");
	AST_RISE: assert property ($rose(breaker_fail_latched_o) |-> breaker_fail_out_o) else $error("rise");
	AST_HOLD: assert property (breaker_fail_latched_o && !latch_clear_in_i |=> breaker_fail_latched_o)
		else $error("hold");
	// Set wins over clear, so only a quiet failure output lets it go
	AST_CLR: assert property (latch_clear_in_i && !breaker_fail_out_o ##1 !breaker_fail_out_o
		|-> ##[0:1] !breaker_fail_latched_o) else $error("clr");
	AST_A_TRIP: assert property (pole_reissue_o[0] && !ext_pole_a_trip_i |-> ##[1:2] !pole_reissue_o[0])
		else $error("trip");
	AST_A_PICK: assert property (pole_reissue_o[0] && !single_pickup_o[0] |-> ##[1:2] !pole_reissue_o[0])
		else $error("pick");
	AST_A_CAUSE: assert property ($rose(pole_reissue_o[0]) |-> $past(ext_pole_a_trip_i && single_pickup_o[0]))
		else $error("cause");
	AST_A_STAY: assert property (pole_reissue_o[0] && ext_pole_a_trip_i && single_pickup_o[0] && unit_enable_i
		|=> pole_reissue_o[0]) else $error("stay");
	COV_RE: cover property ($rose(pole_reissue_o[0]));
	COV_BF: cover property ($rose(breaker_fail_out_o));
	COV_CLR: cover property ($fell(breaker_fail_latched_o));
endmodule : bfl_breaker_failure_asserts
bind bfl_breaker_failure bfl_breaker_failure_asserts bfl_breaker_failure_asserts_i (.*);
`default_nettype wire

// File: bfl_trip_unit.sv
`timescale 1ns/1ns
`default_nettype none
module bfl_trip_unit (
	// Clock and command
	input wire logic ref_clk_i,
	input wire logic [2:0] pole_cmd_i,
	// One trip line per pole
	output logic [2:0] pole_trip_o
);
	always @(negedge ref_clk_i) pole_trip_o <= pole_cmd_i;
endmodule : bfl_trip_unit
`default_nettype wire

// File: tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin n_mismatch++; \
	$display("[ERR] %s exp %0h got %0h", n, e, g); end end
module tb_top;
	localparam int T = 10;
	logic clk = 0, rst = 1, en = 1, it = 0, e3 = 0, cs = 0, gs = 0, clr = 0, tre, bf, bfl;
	logic [2:0] cmd = 0, trip, re;
	logic [3:0] open = 0;
	logic [11:0] mag [4] = '{default: 12'h000};
	// Single threshold above three-phase one, so three-phase runs can leave single paths idle
	logic [11:0] th [3] = '{12'h200, 12'h100, 12'h100};
	logic [7:0] d [6] = '{8'h0A, 8'h06, 8'h07, 8'h05, 8'h08, 8'h05};
	int n_mismatch = 0, tests_run = 0, cyc, seed = 32'h02054951;
	bfl_trip_unit bfl_trip_unit_i (.ref_clk_i(clk), .pole_cmd_i(cmd), .pole_trip_o(trip));
	bfl_breaker_failure #(.TICK_CYCLES(T)) bfl_breaker_failure_i (.ref_clk_i(clk), .reset_i(rst),
		.phase_a_mag_i(mag[0]), .phase_b_mag_i(mag[1]), .phase_c_mag_i(mag[2]), .ground_mag_i(mag[3]),
		.single_pickup_i(th[0]), .three_pickup_i(th[1]), .ground_pickup_i(th[2]),
		.single_fail_delay_i(d[0]), .single_reissue_delay_i(d[1]), .three_oc_fail_delay_i(d[2]),
		.three_oc_reissue_delay_i(d[3]), .no_oc_fail_delay_i(d[4]), .no_oc_reissue_delay_i(d[5]),
		.unit_enable_i(en), .ext_pole_a_trip_i(trip[0]), .ext_pole_b_trip_i(trip[1]), .ext_pole_c_trip_i(trip[2]),
		.ext_three_pole_trip_i(e3), .internal_three_pole_trip_i(it), .contact_position_start_i(cs),
		.pole_a_open_in_i(open[0]), .pole_b_open_in_i(open[1]), .pole_c_open_in_i(open[2]),
		.all_poles_open_in_i(open[3]), .ground_path_start_i(gs), .latch_clear_in_i(clr), .pole_reissue_o(re),
		.three_pole_reissue_o(tre), .breaker_fail_out_o(bf), .breaker_fail_latched_o(bfl), .single_pickup_o(),
		.three_pickup_o(), .ground_pickup_o());
	initial begin
		forever #4 clk = ~clk;
	end
	task automatic at(int c);
		repeat (c - cyc) @(negedge clk);
		cyc = c;
	endtask : at
	// First tick lands anywhere in a tick period, so windows span one tick
	task automatic run(int nr, int nf, logic [3:0] er, logic ef);
		cyc = 0;
		at((nr - 1) * T);
		`CHK("reissue early", 4'h0, {tre, re})
		at(nr * T + 5);
		`CHK("reissue", er, {tre, re})
		at((nf - 1) * T);
		`CHK("fail early", 1'b0, bf)
		at(nf * T + 5);
		`CHK("fail", ef, bf)
		`CHK("latched", ef, bfl)
	endtask : run
	task automatic rel(logic ef);
		cmd <= 0; it <= 0; e3 <= 0; cs <= 0; gs <= 0;
		foreach (mag[i]) mag[i] <= 12'($random(seed) & 255);
		repeat (5) @(negedge clk);
		`CHK("idle", 5'h0, {tre, re, bf})
		`CHK("latched hold", ef, bfl)
		clr <= 1;
		repeat (2) @(negedge clk);
		clr <= 0;
		`CHK("latched clear", 1'b0, bfl)
	endtask : rel
	task automatic print_verdict;
		if (n_mismatch == 0 && tests_run > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : print_verdict
	initial begin
		repeat (16) @(negedge clk);
		rst = 0;
		for (int p = 0; p < 3; p++) begin
			mag[p] <= 12'h200 + 12'($random(seed) & 255);
			cmd <= 3'(1 << p);
			run(6, 10, 4'(1 << p), 1);
			rel(1);
		end
		// Out of service: a full single-pole start must stay quiet
		en <= 0; mag[0] <= 12'h3FF; cmd <= 3'h1;
		run(6, 10, 4'h0, 1'b0);
		rel(1'b0);
		en <= 1;
		for (int s = 0; s < 3; s++) begin
			mag[s] <= 12'h100 + 12'($random(seed) & 255);
			it <= s == 0; cmd <= s == 1 ? 3'h7 : 3'h0; e3 <= s == 2;
			run(5, 7, 4'h8, 1);
			rel(1);
		end
		for (int s = 0; s < 3; s++) begin
			cs <= s != 1; gs <= s == 1; open <= s == 2 ? 4'hF : 4'h7; mag[3] <= 12'h1FF;
			run(5, 8, s == 2 ? 4'h0 : 4'h8, s != 2);
			rel(s != 2);
		end
		print_verdict;
	end
	initial begin
		repeat (5000) @(posedge clk);
		n_mismatch++;
		print_verdict;
	end
endmodule : tb_top
`default_nettype wire
